// File: core/protocol_select_config.v
// Protocol selection and type B transmit option registers of the reader front end.
// Assumes host strobes and decoder outputs on clock; enable pin and subcarrier are async.
//
// Local design decision: the plain strobed port.
`include "protocol_select_config_consts.vh"

module protocol_select_config (
    // Clock and reset
    input  wire       clock,
    input  wire       rst,
    // Enable pin, active high, asynchronous
    input  wire       enable_pin,
    // Register port
    input  wire [4:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr_en,
    input  wire       rd_en,
    output reg  [7:0] rdata,
    // Host stop condition ends direct mode
    input  wire       host_stop,
    // Receive path sources
    input  wire       subcarrier_pin,
    input  wire [4:0] dec_bit,
    input  wire [4:0] dec_clk,
    // Rate split from the type A high rate logic
    input  wire       tx_rate_split,
    input  wire [1:0] tx_rate_alt,
    // Type B transmitter byte events
    input  wire       tx_byte_done,
    input  wire       tx_byte_last,
    // Protocol decode
    output reg        rx_crc_check,
    output reg        sel_single_sub,
    output reg        sel_double_sub,
    output reg        sel_prox_a,
    output reg        sel_prox_b,
    output reg        sel_tag_prop,
    output reg        sel_undefined,
    output reg        high_rate,
    output reg        coding_256,
    output reg  [1:0] prox_rx_rate,
    output reg  [1:0] prox_tx_rate,
    // Type B framing lengths in etu
    output reg  [2:0] guard_etu,
    output reg  [3:0] frame_end_low_len,
    output reg  [1:0] frame_start_high_len,
    output reg  [3:0] frame_start_low_len,
    output reg  [2:0] byte_guard_etu,
    // Type A high rate options as stored
    output reg  [7:0] typea_options,
    // Direct mode pins
    output reg        direct_active,
    output reg        io6_out,
    output reg        io6_oe,
    output reg        io5_out,
    output reg        io5_oe
);
    reg  [7:0] chip_ctrl_reg;
    reg  [7:0] protocol_select_reg;
    reg  [7:0] typeb_tx_options_reg;
    reg  [7:0] typea_high_rate_options_reg;
    reg  [7:0] rdata_next;
    wire       enable_level;
    wire       subcarrier_level;
    wire       bank_clear;
    wire [4:0] code;
    wire       direct_type;
    reg  [2:0] family;
    reg        fam_bit;
    reg        fam_clk;
    // Write strobes and decoded fields
    wire       wr_chip_ctrl;
    wire       wr_protocol_select;
    wire       wr_typeb_tx_opt;
    wire       wr_typea_hr_opt;
    wire       is_vicinity;
    wire       is_proximity;
    wire [1:0] code_rate;
    wire [2:0] guard_field;
    wire       guard_every;

    // Family index codes; all but FAM_NONE double as decoder lane numbers
    localparam [2:0] FAM_SINGLE = 3'h0;
    localparam [2:0] FAM_DOUBLE = 3'h1;
    localparam [2:0] FAM_PROX_A = 3'h2;
    localparam [2:0] FAM_PROX_B = 3'h3;
    localparam [2:0] FAM_TAG    = 3'h4;
    localparam [2:0] FAM_NONE   = 3'h7;

    pin_filter #(
        .RESET_LEVEL (1'b0)
    ) u_enable_filter (
        .clock     (clock),
        .rst       (rst),
        .pin       (enable_pin),
        .level_reg (enable_level)
    );

    pin_filter #(
        .RESET_LEVEL (1'b0)
    ) u_subcarrier_filter (
        .clock     (clock),
        .rst       (rst),
        .pin       (subcarrier_pin),
        .level_reg (subcarrier_level)
    );

    // Enable low holds the whole bank at defaults
    assign bank_clear  = rst | ~enable_level;
    assign code        = protocol_select_reg[4:0];
    assign direct_type = protocol_select_reg[`BIT_DIRECT_TYPE];

    // One strobe per register, decoded once
    assign wr_chip_ctrl       = wr_en & (addr == `OFS_CHIP_CTRL);
    assign wr_protocol_select = wr_en & (addr == `OFS_PROTOCOL_SELECT);
    assign wr_typeb_tx_opt    = wr_en & (addr == `OFS_TYPEB_TX_OPT);
    assign wr_typea_hr_opt    = wr_en & (addr == `OFS_TYPEA_HR_OPT);

    // Decoded views of the stored fields
    assign is_vicinity  = (family == FAM_SINGLE) | (family == FAM_DOUBLE);
    assign is_proximity = (family == FAM_PROX_A) | (family == FAM_PROX_B);
    assign code_rate    = code[1:0];
    assign guard_field  = typeb_tx_options_reg[`GUARD_MSB:`GUARD_LSB];
    assign guard_every  = typeb_tx_options_reg[`BIT_GUARD_EVERY];

    // Register writes
    always @(posedge clock) begin
        if (bank_clear) begin
            chip_ctrl_reg               <= `RST_CHIP_CTRL;
            protocol_select_reg         <= `RST_PROTOCOL_SELECT;
            typeb_tx_options_reg        <= `RST_TYPEB_TX_OPT;
            typea_high_rate_options_reg <= `RST_TYPEA_HR_OPT;
        end else begin
            if (wr_chip_ctrl) begin
                chip_ctrl_reg <= wdata & `MASK_CHIP_CTRL;
            end else if (host_stop) begin
                // Stop condition terminates direct mode
                chip_ctrl_reg[`BIT_DIRECT_ENABLE] <= 1'b0;
            end
            // A protocol change invalidates the type A options
            if (wr_protocol_select) begin
                protocol_select_reg         <= wdata & `MASK_PROTOCOL_SEL;
                typea_high_rate_options_reg <= `RST_TYPEA_HR_OPT;
            end else if (wr_typea_hr_opt) begin
                typea_high_rate_options_reg <= wdata & `MASK_TYPEA_HR_OPT;
            end
            if (wr_typeb_tx_opt) begin
                typeb_tx_options_reg <= wdata & `MASK_TYPEB_TX_OPT;
            end
        end
    end

    // Read decode, unmapped addresses read zero
    always @* begin
        if (addr == `OFS_CHIP_CTRL) begin
            rdata_next = chip_ctrl_reg;
        end else if (addr == `OFS_PROTOCOL_SELECT) begin
            rdata_next = protocol_select_reg;
        end else if (addr == `OFS_TYPEB_TX_OPT) begin
            rdata_next = typeb_tx_options_reg;
        end else if (addr == `OFS_TYPEA_HR_OPT) begin
            rdata_next = typea_high_rate_options_reg;
        end else begin
            rdata_next = 8'h00;
        end
    end

    // Zero outside the answer cycle, so a stale byte never reads as fresh
    always @(posedge clock) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (rd_en) begin
            rdata <= rdata_next;
        end else begin
            rdata <= 8'h00;
        end
    end

    // Family index: 0 single, 1 double, 2 type A, 3 type B, 4 tag, 7 none
    always @* begin
        if (code[4:2] == 3'h0) begin
            family = FAM_SINGLE;
        end else if (code[4:2] == 3'h1) begin
            family = FAM_DOUBLE;
        end else if (code[4:2] == 3'h2) begin
            family = FAM_PROX_A;
        end else if (code[4:2] == 3'h3) begin
            family = FAM_PROX_B;
        end else if (code == `CODE_TAG_PROP) begin
            family = FAM_TAG;
        end else begin
            family = FAM_NONE;
        end
    end

    // Decoder chosen by the protocol field feeds the direct pins
    // Undefined codes park the pins low instead of passing a stray lane
    always @* begin
        if (family <= FAM_TAG) begin
            fam_bit = dec_bit[family];
            fam_clk = dec_clk[family];
        end else begin
            fam_bit = 1'b0;
            fam_clk = 1'b0;
        end
    end

    // Protocol decode outputs
    always @(posedge clock) begin
        if (bank_clear) begin
            rx_crc_check   <= 1'b1;
            sel_single_sub <= 1'b0;
            sel_double_sub <= 1'b0;
            sel_prox_a     <= 1'b0;
            sel_prox_b     <= 1'b0;
            sel_tag_prop   <= 1'b0;
            sel_undefined  <= 1'b0;
            high_rate      <= 1'b0;
            coding_256     <= 1'b0;
            prox_rx_rate   <= 2'h0;
            prox_tx_rate   <= 2'h0;
            typea_options  <= 8'h00;
        end else begin
            rx_crc_check   <= ~protocol_select_reg[`BIT_RX_CRC_OFF];
            sel_single_sub <= (family == FAM_SINGLE);
            sel_double_sub <= (family == FAM_DOUBLE);
            sel_prox_a     <= (family == FAM_PROX_A);
            sel_prox_b     <= (family == FAM_PROX_B);
            sel_tag_prop   <= (family == FAM_TAG);
            sel_undefined  <= (family == FAM_NONE);
            // Vicinity: bit 1 rate, bit 0 coding
            high_rate      <= is_vicinity & code[1];
            coding_256     <= is_vicinity & code[0];
            // Proximity rate codes 0 to 3 run 106, 212, 424, 848 kbps
            if (is_proximity) begin
                prox_rx_rate <= code_rate;
                // Split rate leaves the code governing receive only
                prox_tx_rate <= tx_rate_split ? tx_rate_alt : code_rate;
            end else begin
                prox_rx_rate <= 2'h0;
                prox_tx_rate <= 2'h0;
            end
            typea_options  <= typea_high_rate_options_reg;
        end
    end

    // Type B framing lengths
    always @(posedge clock) begin
        if (bank_clear) begin
            guard_etu            <= 3'h0;
            frame_end_low_len    <= `ETU_SHORT_LOW;
            frame_start_high_len <= `ETU_SHORT_HIGH;
            frame_start_low_len  <= `ETU_SHORT_LOW;
        end else begin
            guard_etu <= guard_field;
            frame_end_low_len <= typeb_tx_options_reg[`BIT_END_LOW_LEN] ?
                `ETU_LONG_LOW : `ETU_SHORT_LOW;
            frame_start_high_len <= typeb_tx_options_reg[`BIT_START_HIGH_LEN] ?
                `ETU_LONG_HIGH : `ETU_SHORT_HIGH;
            frame_start_low_len <= typeb_tx_options_reg[`BIT_START_LOW_LEN] ?
                `ETU_LONG_LOW : `ETU_SHORT_LOW;
        end
    end

    // Guard after each type B character, zero after the last unless the every bit is set, held until the next byte ends
    always @(posedge clock) begin
        if (bank_clear) begin
            byte_guard_etu <= 3'h0;
        end else if (tx_byte_done) begin
            // Latched per byte, so a write mid-frame only affects later bytes
            if (tx_byte_last && !guard_every) begin
                byte_guard_etu <= 3'h0;
            end else begin
                byte_guard_etu <= guard_field;
            end
        end
    end

    // Direct mode pins; the type bit picks subcarrier on io6 alone or decoder bit and clock on io6 and io5
    always @(posedge clock) begin
        if (bank_clear) begin
            direct_active <= 1'b0;
            io6_out       <= 1'b0;
            io6_oe        <= 1'b0;
            io5_out       <= 1'b0;
            io5_oe        <= 1'b0;
        end else begin
            direct_active <= chip_ctrl_reg[`BIT_DIRECT_ENABLE];
            if (!chip_ctrl_reg[`BIT_DIRECT_ENABLE]) begin
                io6_out <= 1'b0;
                io6_oe  <= 1'b0;
                io5_out <= 1'b0;
                io5_oe  <= 1'b0;
            end else if (!direct_type) begin
                io6_out <= subcarrier_level;
                io6_oe  <= 1'b1;
                io5_out <= 1'b0;
                io5_oe  <= 1'b0;
            end else begin
                io6_out <= fam_bit;
                io6_oe  <= 1'b1;
                io5_out <= fam_clk;
                io5_oe  <= 1'b1;
            end
        end
    end
endmodule // protocol_select_config

// File: core/protocol_select_config_consts.vh
// Offsets, field positions, reset values and encodings of the protocol selection bank.
// Assumes an 8-bit register port with 5-bit addresses on a single 100 MHz clock.
`ifndef PROTOCOL_SELECT_CONFIG_CONSTS_VH
`define PROTOCOL_SELECT_CONFIG_CONSTS_VH

`define ADDR_W              5
`define OFS_CHIP_CTRL       5'h00
`define OFS_PROTOCOL_SELECT 5'h01
`define OFS_TYPEB_TX_OPT    5'h02
`define OFS_TYPEA_HR_OPT    5'h03

`define RST_CHIP_CTRL       8'h00
`define RST_PROTOCOL_SELECT 8'h02
`define RST_TYPEB_TX_OPT    8'h00
`define RST_TYPEA_HR_OPT    8'h00

`define MASK_CHIP_CTRL      8'h40
`define MASK_PROTOCOL_SEL   8'hdf
`define MASK_TYPEB_TX_OPT   8'hfe
`define MASK_TYPEA_HR_OPT   8'hf8

`define BIT_DIRECT_ENABLE   6
`define BIT_RX_CRC_OFF      7
`define BIT_DIRECT_TYPE     6
`define BIT_GUARD_EVERY     1
`define BIT_END_LOW_LEN     4
`define BIT_START_HIGH_LEN  3
`define BIT_START_LOW_LEN   2
`define GUARD_MSB           7
`define GUARD_LSB           5

`define CODE_TAG_PROP       5'h13

`define ETU_LONG_LOW        4'hb
`define ETU_SHORT_LOW       4'ha
`define ETU_LONG_HIGH       2'h3
`define ETU_SHORT_HIGH      2'h2

`endif

// File: core/pin_filter.v
// Three-stage synchroniser for a pin input with a two-sample agreement filter.
// Assumes the pin is asynchronous to clock; output settles after four edges.
module pin_filter #(
    parameter RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input  wire clock,
    input  wire rst,
    // Pin and filtered level
    input  wire pin,
    output reg  level_reg
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    always @(posedge clock) begin
        if (rst) begin
            s1_reg    <= RESET_LEVEL;
            s2_reg    <= RESET_LEVEL;
            s3_reg    <= RESET_LEVEL;
            level_reg <= RESET_LEVEL;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // Only a level seen on two samples counts
            if (s2_reg == s3_reg) begin
                level_reg <= s3_reg;
            end
        end
    end
endmodule // pin_filter

// File: verif/host_bus_model.sv
// Host side of the register port: single-byte writes and reads.
// Assumes the bank answers a read in the cycle after the strobe, never stalls.
module host_bus_model (
    // Clock
    input  logic       clock,
    // Register port
    output logic [4:0] addr,
    output logic [7:0] wdata,
    output logic       wr_en,
    output logic       rd_en,
    input  logic [7:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        addr = 5'h1f;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
    end

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= (a == 5'h01) ? (d & 8'hdf) : d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        // Idle bus shows junk, not the last byte
        addr <= ~a;
        wdata <= ~d;
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        addr <= ~a;
        #1 d = rdata;
    endtask
endmodule // host_bus_model

// File: verif/protocol_select_config_properties.sv
// Port assertions for the protocol selection bank.
// Assumes one clock; checks are off while rst is high or the enable pin is low.
module protocol_select_config_checker (
    // Clock and controls
    input logic       clock,
    input logic       rst,
    input logic       enable_pin,
    input logic       host_stop,
    // Register port
    input logic [4:0] addr,
    input logic [7:0] wdata,
    input logic       wr_en,
    input logic       rd_en,
    input logic [7:0] rdata,
    // Transmit byte events
    input logic       tx_byte_done,
    input logic       tx_byte_last,
    // Decoded outputs
    input logic       rx_crc_check,
    input logic [2:0] guard_etu,
    input logic [3:0] frame_end_low_len,
    input logic [1:0] frame_start_high_len,
    input logic [3:0] frame_start_low_len,
    input logic [2:0] byte_guard_etu,
    input logic [7:0] typea_options,
    input logic       direct_active,
    input logic       io6_oe,
    input logic       io5_oe
);
    // Placement bit and guard field shadowed from the bus; guard_etu lags
    // a write by two cycles, one behind the register, and would mislead for a byte right after it
    logic       every_reg;
    logic [2:0] guard_reg;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || !enable_pin);

    always @(posedge clock) begin
        if (rst || !enable_pin) begin
            every_reg <= 1'b0;
            guard_reg <= 3'h0;
        end else if (wr_en && addr == 5'h02) begin
            every_reg <= wdata[1];
            guard_reg <= wdata[7:5];
        end
    end

    chk_crc_follows: assert property (
        wr_en && addr == 5'h01 |-> ##2 rx_crc_check == !$past(wdata[7], 2))
        else $error("crc check output wrong after write");
    chk_typea_clear: assert property (
        wr_en && addr == 5'h01 ##1 !(wr_en && addr == 5'h03) |-> ##1 typea_options == 8'h00)
        else $error("type A options not cleared");
    chk_typeb_lens: assert property (
        wr_en && addr == 5'h02 |-> ##2 guard_etu == $past(wdata[7:5], 2)
        && frame_end_low_len == ($past(wdata[4], 2) ? 4'hb : 4'ha)
        && frame_start_high_len == ($past(wdata[3], 2) ? 2'h3 : 2'h2)
        && frame_start_low_len == ($past(wdata[2], 2) ? 4'hb : 4'ha))
        else $error("type B lengths wrong");
    chk_rdata_idle: assert property (
        !rd_en |=> rdata == 8'h00)
        else $error("read data outside read cycle");
    chk_byte_guard: assert property (
        tx_byte_done |=> byte_guard_etu ==
        (($past(tx_byte_last) && !$past(every_reg)) ? 3'h0 : $past(guard_reg)))
        else $error("byte guard wrong");
    chk_direct_on: assert property (
        wr_en && addr == 5'h00 && wdata[6] && !host_stop ##1 !host_stop
        |-> ##1 direct_active && io6_oe)
        else $error("direct mode not entered");
    chk_direct_off: assert property (
        !direct_active |-> !io6_oe && !io5_oe)
        else $error("pins driven outside direct mode");
    chk_stop_ends: assert property (
        host_stop && !(wr_en && addr == 5'h00) |-> ##2 !direct_active)
        else $error("stop left direct mode on");
endmodule // protocol_select_config_checker

bind protocol_select_config protocol_select_config_checker protocol_select_config_checker_i (
    .clock(clock), .rst(rst), .enable_pin(enable_pin), .host_stop(host_stop),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .tx_byte_done(tx_byte_done), .tx_byte_last(tx_byte_last), .rx_crc_check(rx_crc_check),
    .guard_etu(guard_etu), .frame_end_low_len(frame_end_low_len),
    .frame_start_high_len(frame_start_high_len), .frame_start_low_len(frame_start_low_len),
    .byte_guard_etu(byte_guard_etu), .typea_options(typea_options),
    .direct_active(direct_active), .io6_oe(io6_oe), .io5_oe(io5_oe));

// File: verif/protocol_select_config_tb.sv
// Register-level tests of the protocol selection bank.
// Assumes host_bus_model drives the register port; checker is bound separately.
module protocol_select_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, rst = 1'b1, enable_pin = 1'b1, host_stop = 1'b0, subcarrier_pin = 1'b0;
    logic tx_rate_split = 1'b0, tx_byte_done = 1'b0, tx_byte_last = 1'b0;
    logic [4:0] dec_bit = 5'h00, dec_clk = 5'h00;
    logic [1:0] tx_rate_alt = 2'h0;
    wire  [4:0] addr;
    wire  [7:0] wdata, rdata, typea_options;
    wire        wr_en, rd_en, rx_crc_check, sel_single_sub, sel_double_sub, sel_prox_a;
    wire        sel_prox_b, sel_tag_prop, sel_undefined, high_rate, coding_256;
    wire        direct_active, io6_out, io6_oe, io5_out, io5_oe;
    wire  [1:0] prox_rx_rate, prox_tx_rate, frame_start_high_len;
    wire  [2:0] guard_etu, byte_guard_etu;
    wire  [3:0] frame_end_low_len, frame_start_low_len;
    logic [7:0] d;
    logic [7:0] vals[4] = '{8'hff, 8'h00, 8'ha4, 8'h5a};
    logic [5:0] sel;
    int n_fail = 0, checks = 0, c;

    always #5 clock = ~clock;

    host_bus_model host_bus_model_i (.clock(clock), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));
    protocol_select_config protocol_select_config_i (.clock(clock), .rst(rst),
        .enable_pin(enable_pin), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .host_stop(host_stop), .subcarrier_pin(subcarrier_pin),
        .dec_bit(dec_bit), .dec_clk(dec_clk), .tx_rate_split(tx_rate_split),
        .tx_rate_alt(tx_rate_alt), .tx_byte_done(tx_byte_done), .tx_byte_last(tx_byte_last),
        .rx_crc_check(rx_crc_check), .sel_single_sub(sel_single_sub),
        .sel_double_sub(sel_double_sub), .sel_prox_a(sel_prox_a), .sel_prox_b(sel_prox_b),
        .sel_tag_prop(sel_tag_prop), .sel_undefined(sel_undefined), .high_rate(high_rate),
        .coding_256(coding_256), .prox_rx_rate(prox_rx_rate), .prox_tx_rate(prox_tx_rate),
        .guard_etu(guard_etu), .frame_end_low_len(frame_end_low_len),
        .frame_start_high_len(frame_start_high_len),
        .frame_start_low_len(frame_start_low_len), .byte_guard_etu(byte_guard_etu),
        .typea_options(typea_options), .direct_active(direct_active), .io6_out(io6_out),
        .io6_oe(io6_oe), .io5_out(io5_out), .io5_oe(io5_oe));

    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        host_bus_model_i.wr(a, v);
    endtask
    task automatic rd(input logic [4:0] a);
        host_bus_model_i.rd(a, d);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic pulse(input logic last);
        @(posedge clock);
        tx_byte_done <= 1'b1;
        tx_byte_last <= last;
        @(posedge clock);
        tx_byte_done <= 1'b0;
        #1;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #500000;
        n_fail++;
        results();
    end

    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        wt(6);
        cmp({rx_crc_check, sel_single_sub, high_rate, coding_256}, 16'he);
        rd(5'h01);
        cmp(d, 16'h02);
        rd(5'h02);
        cmp(d, 16'h00);
        rd(5'h10);
        cmp(d, 16'h00);
        $display("test reset done");
        for (c = 0; c < 21; c++) begin
            if (c < 16 || c > 18) begin
                wr(5'h01, {c[0], 2'b00, c[4:0]});
                rd(5'h01);
                cmp(d, {c[0], 2'b00, c[4:0]});
                sel = c < 4 ? 6'h20 : c < 8 ? 6'h10 : c < 12 ? 6'h08 : c < 16 ? 6'h04
                    : c == 19 ? 6'h02 : 6'h01;
                cmp({sel_single_sub, sel_double_sub, sel_prox_a, sel_prox_b, sel_tag_prop,
                    sel_undefined, high_rate, coding_256, prox_rx_rate, prox_tx_rate,
                    rx_crc_check}, {sel, (c < 8) ? c[1:0] : 2'h0, c[3] ? c[1:0] : 2'h0,
                    c[3] ? c[1:0] : 2'h0, !c[0]});
            end
        end
        wr(5'h03, 8'hff);
        rd(5'h03);
        cmp(d, 16'hf8);
        cmp(typea_options, 16'hf8);
        wr(5'h01, 8'h0d);
        rd(5'h03);
        cmp(d, 16'h00);
        cmp(typea_options, 16'h00);
        @(posedge clock);
        tx_rate_split <= 1'b1;
        tx_rate_alt <= 2'h2;
        wt(2);
        cmp({prox_rx_rate, prox_tx_rate}, 16'h6);
        $display("test protocol done");
        foreach (vals[i]) begin
            wr(5'h02, vals[i]);
            rd(5'h02);
            cmp(d, vals[i] & 8'hfe);
            cmp({guard_etu, frame_end_low_len, frame_start_high_len, frame_start_low_len},
                {vals[i][7:5], vals[i][4] ? 4'hb : 4'ha, vals[i][3] ? 2'h3 : 2'h2,
                vals[i][2] ? 4'hb : 4'ha});
            pulse(1'b1);
            cmp(byte_guard_etu, vals[i][1] ? vals[i][7:5] : 3'h0);
            pulse(1'b0);
            cmp(byte_guard_etu, vals[i][7:5]);
        end
        $display("test typeb done");
        wr(5'h01, 8'h02);
        subcarrier_pin <= 1'b1;
        wr(5'h00, 8'hff);
        rd(5'h00);
        cmp(d, 16'h40);
        wt(8);
        cmp({direct_active, io6_out, io6_oe, io5_oe}, 16'he);
        @(posedge clock);
        subcarrier_pin <= 1'b0;
        wt(8);
        cmp(io6_out, 16'h0);
        @(posedge clock);
        host_stop <= 1'b1;
        @(posedge clock);
        host_stop <= 1'b0;
        wt(2);
        cmp({direct_active, io6_oe, io5_oe}, 16'h0);
        wr(5'h01, 8'h42);
        subcarrier_pin <= 1'b0;
        dec_bit <= 5'h01;
        dec_clk <= 5'h01;
        wr(5'h00, 8'h40);
        wt(3);
        cmp({direct_active, io6_out, io6_oe, io5_out, io5_oe}, 16'h1f);
        wr(5'h01, 8'h4c);
        wt(3);
        cmp({io6_out, io5_out}, 16'h0);
        wr(5'h00, 8'h00);
        wt(2);
        cmp({direct_active, io6_oe, io5_oe}, 16'h0);
        $display("test direct done");
        wr(5'h02, 8'hff);
        @(posedge clock);
        enable_pin <= 1'b0;
        wt(6);
        @(posedge clock);
        enable_pin <= 1'b1;
        wt(8);
        rd(5'h01);
        cmp(d, 16'h02);
        rd(5'h02);
        cmp(d, 16'h00);
        $display("test enable done");
        results();
    end
endmodule // protocol_select_config_tb
